// >>> loop_device_config_and_srq_test.sv
// Self-checking bench for the loop device core
`timescale 1ns/1ps
module loop_device_config_and_srq_test;
   logic i_clk = 0, i_rst = 1, i_reset_n = 1, i_cs_n = 1, i_rd_n = 1, i_wr_n = 1, go = 0;
   logic i_irq_req = 0, i_spare_flag_input_a = 0, i_spare_flag_input_b = 0;
   logic i_system_controller_strap_n = 1;  // Not the system controller
   logic [2:0]  i_register_select_lines = 3'h0, i_rx_ctl, o_tx_ctl;
   logic [7:0]  i_bus = 8'h00, rb, i_rx_data, o_bus, o_tx_data;
   logic [10:0] frm = 11'h0, rxf, last;
   logic        i_rx_valid, o_bus_oe, o_irq_n_o, o_irq_n_oe, o_tx_valid, o_master_clear;
   logic [14:0] rows [8] = '{15'h0528, 15'h19e3, 15'h3006, 15'h42d1,
                             15'h57fb, 15'h740f, 15'h6214, 15'h3807};
   int ntx = 0, n0, mismatches = 0, num_checks = 0;
   lpd_core u_dut (.*);
   lpd_loop u_loop (.i_clk(i_clk), .i_go(go), .i_frm(frm), .o_valid(i_rx_valid), .o_frm(rxf));
   assign i_rx_ctl = rxf[10:8];
   assign i_rx_data = rxf[7:0];
   always #10 i_clk = ~i_clk;
   always @(posedge i_clk) if (o_tx_valid) begin
      last <= {o_tx_ctl, o_tx_data};
      ntx <= ntx + 1;
   end
   task chk(input string n, input logic [10:0] e, input logic [10:0] g);
      num_checks++;
      if (g !== e) begin
         mismatches++;
         $display("[ERR] %s expected %h seen %h", n, e, g);
      end
   endtask
   task wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge i_clk) #1;
      {i_register_select_lines, i_bus, i_cs_n, i_wr_n} = {a, d, 2'b00};
      repeat (3) @(posedge i_clk);
      #1 i_wr_n = 1;
      repeat (4) @(posedge i_clk);
      #1 i_cs_n = 1;
      repeat (3) @(posedge i_clk);
      #1;
   endtask
   task rd(input logic [2:0] a);
      @(posedge i_clk) #1;
      {i_register_select_lines, i_cs_n, i_rd_n} = {a, 2'b00};
      repeat (5) @(posedge i_clk);
      #1 rb = o_bus;
      chk("bus_oe", 11'h1, {10'h0, o_bus_oe});
      {i_cs_n, i_rd_n} = 2'b11;
      repeat (3) @(posedge i_clk);
      #1;
   endtask
   task rx(input logic [10:0] f);
      n0 = ntx;
      @(posedge i_clk) #1;
      {go, frm} = {1'b1, f};
      @(posedge i_clk) #1 go = 0;
      repeat (2) @(posedge i_clk);
      #1;
   endtask
   task src(input logic [2:0] c, input logic [7:0] d);
      wr(3'h1, {5'h0, c});
      n0 = ntx;
      wr(3'h2, d);
   endtask
   task tally_and_finish;
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   initial begin
      repeat (5000) @(posedge i_clk);
      mismatches++;
      tally_and_finish;
   end
   initial begin
      repeat (6) @(posedge i_clk);
      #1 i_rst = 0;
      rd(3'h0); chk("status", 11'h80, rb);
      rd(3'h3); chk("poll_cfg", 11'h0, rb);
      // Rows: send request bit, loop frame in, control bits expected out
      foreach (rows[i]) begin  // One host pass per loop frame
         wr(3'h0, {4'h0, rows[i][14], 3'h0});
         rx(rows[i][13:3]);
         chk("rx_count", 11'h1, 11'(ntx - n0));
         chk("rx_frame", {rows[i][2:0], rows[i][10:3]}, last);
      end
      wr(3'h3, 8'h3a); rd(3'h3); chk("poll_cfg", 11'h3a, rb);
      wr(3'h3, 8'h2a); rd(3'h3); chk("poll_cfg", 11'h2a, rb);
      wr(3'h3, 8'h0a); rd(3'h3); chk("poll_cfg", 11'h0a, rb);
      wr(3'h4, 8'h9f); rd(3'h4); chk("loop_addr", 11'h9f, rb);
      wr(3'h4, 8'h00); rd(3'h4); chk("loop_addr", 11'h0, rb);
      src(3'h7, 8'h00); chk("idy", 11'h700, last);
      chk("idy_count", 11'h1, 11'(ntx - n0));
      wr(3'h2, 8'h00); chk("idy_repeat", 11'h2, 11'(ntx - n0));
      wr(3'h0, 8'h00); src(3'h2, 8'hc3); chk("doe", 11'h2c3, last);
      wr(3'h0, 8'h08); src(3'h0, 8'h77); chk("doe_srq", 11'h177, last);
      wr(3'h0, 8'h40); rd(3'h0); chk("ctl_role", 11'h40, {3'h0, rb & 8'h70});
      wr(3'h0, 8'h20); rd(3'h0); chk("src_role", 11'h20, {3'h0, rb & 8'h70});
      wr(3'h0, 8'h10); rd(3'h0); chk("lsn_role", 11'h10, {3'h0, rb & 8'h70});
      i_spare_flag_input_a = 1;
      rd(3'h7); chk("spare", 11'h1, {9'h0, rb[7:6]});
      {i_spare_flag_input_a, i_spare_flag_input_b} = 2'b01;
      rd(3'h7); chk("spare", 11'h2, {9'h0, rb[7:6]});
      i_irq_req = 1;  // Host keeps its request up while changes pend
      repeat (3) @(posedge i_clk);
      #1 chk("irq_oe", 11'h1, {10'h0, o_irq_n_oe});
      {i_irq_req, i_system_controller_strap_n, i_reset_n} = 3'b000;
      repeat (5) @(posedge i_clk);
      #1 i_reset_n = 1;
      rd(3'h0); chk("status_clr", 11'h84, {3'h0, rb & 8'h84});
      rx(11'h0a5); chk("clr_count", 11'h0, 11'(ntx - n0));
      wr(3'h0, 8'h00); rd(3'h0); chk("status", 11'h0, {3'h0, rb & 8'h80});
      tally_and_finish;
   end
endmodule

// >>> lpd_chk.sv
// Port assertions for the loop device core
`timescale 1ns/1ps
module lpd_chk (
   input wire logic       i_clk,
   input wire logic       i_rst,
   input wire logic       i_reset_n,
   input wire logic       i_cs_n,
   input wire logic       i_rd_n,
   input wire logic       i_rx_valid,
   input wire logic [2:0] i_rx_ctl,
   input wire logic [7:0] i_rx_data,
   input wire logic       o_bus_oe,
   input wire logic       o_irq_n_o,
   input wire logic       o_irq_n_oe,
   input wire logic       o_tx_valid,
   input wire logic [2:0] o_tx_ctl,
   input wire logic [7:0] o_tx_data,
   input wire logic       o_master_clear
);
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_rst);
   property p_irq_low; o_irq_n_o == 1'b0; endproperty
   a_irq_low: assert property (p_irq_low) else $error("irq drives high");
   property p_irq_mc; o_master_clear [*2] |-> !o_irq_n_oe; endproperty
   a_irq_mc: assert property (p_irq_mc) else $error("irq during clear");
   property p_rst_mc; $fell(i_rst) |-> o_master_clear; endproperty
   a_rst_mc: assert property (p_rst_mc) else $error("no clear after reset");
   property p_pin_mc; !i_reset_n [*4] |=> o_master_clear; endproperty
   a_pin_mc: assert property (p_pin_mc) else $error("reset pin ignored");
   property p_cs_off; i_cs_n [*3] |-> !o_bus_oe; endproperty
   a_cs_off: assert property (p_cs_off) else $error("bus driven unselected");
   property p_rd_on; (!i_cs_n && !i_rd_n) [*3] |-> o_bus_oe; endproperty
   a_rd_on: assert property (p_rd_on) else $error("bus not driven on read");
   property p_ctl_keep;
      i_rx_valid && !o_master_clear |=> o_tx_valid && o_tx_ctl[2:1] == $past(i_rx_ctl[2:1])
         && o_tx_data == $past(i_rx_data);
   endproperty
   a_ctl_keep: assert property (p_ctl_keep) else $error("frame altered");
   property p_mc_quiet; o_master_clear [*2] |-> !o_tx_valid; endproperty
   a_mc_quiet: assert property (p_mc_quiet) else $error("frame during clear");
   c_rx: cover property (i_rx_valid && !o_master_clear);
   c_rd: cover property (o_bus_oe);
   c_idy: cover property (o_tx_valid && o_tx_ctl == 3'h7);
endmodule
bind lpd_core lpd_chk u_chk (.*);

// >>> lpd_consts.vh
// Constants for the loop device host port and frame service-request logic
`ifndef LPD_CONSTS_VH
`define LPD_CONSTS_VH
// Register select codes (three-bit index on the host port)
`define LPD_REG_STATUS     3'h0
`define LPD_REG_FRAME_CTL  3'h1
`define LPD_REG_FRAME_DATA 3'h2
`define LPD_REG_POLL_CFG   3'h3
`define LPD_REG_LOOP_ADDR  3'h4
`define LPD_REG_SCRATCH_A  3'h5
`define LPD_REG_SCRATCH_B  3'h6
`define LPD_REG_AUX_IN     3'h7
// Status register bit positions
`define LPD_ST_MASTER_CLR  7
`define LPD_ST_CTL_ROLE    6
`define LPD_ST_SRC_ROLE    5
`define LPD_ST_LSN_ROLE    4
`define LPD_ST_SEND_SRQ    3
`define LPD_ST_SYS_CTL     2
// Poll response register fields
`define LPD_PP_ENABLE      4
`define LPD_PP_STATUS      5
// Loop address register fields
`define LPD_LA_CONFIGURED  7
// Frame control field: bit 0 of the 3-bit control is the service-request bit
`define LPD_FC_SRQ         0
`define LPD_FC_DOE_MSB     1'b0
`define LPD_FC_IDY         2'h3
// Auxiliary input register bit positions
`define LPD_AUX_A          6
`define LPD_AUX_B          7
// Reset values
`define LPD_RST_BYTE       8'h00
`define LPD_RST_STATUS     8'h80
`define LPD_RST_CTL        3'h0
`define LPD_RST_SYNC       2'h3
`endif

// >>> lpd_core.v
// Host register port and frame path of the loop device core
// Notes on behaviour
// - Send request forces request bit on DOE and IDY frames
// - Request bit passes unchanged when control clear
// - Interrupt output open drain, active low
// - Spare flag inputs readable by host
// - Three-bit register select plus chip select
// - Strobes, select, reset, interrupt active low
// - Reset low sets master clear; master clear clears frame control and data
`timescale 1ns/1ps
module lpd_core (
   input  wire       i_clk,
   input  wire       i_rst,
   input  wire       i_reset_n,
   input  wire       i_cs_n,
   input  wire       i_rd_n,
   input  wire       i_wr_n,
   input  wire [2:0] i_register_select_lines,
   input  wire [7:0] i_bus,
   output reg  [7:0] o_bus,
   output wire       o_bus_oe,
   output wire       o_irq_n_o,
   output wire       o_irq_n_oe,
   input  wire       i_irq_req,
   input  wire       i_spare_flag_input_a,
   input  wire       i_spare_flag_input_b,
   input  wire       i_system_controller_strap_n,
   input  wire       i_rx_valid,
   input  wire [2:0] i_rx_ctl,
   input  wire [7:0] i_rx_data,
   output wire       o_tx_valid,
   output wire [2:0] o_tx_ctl,
   output wire [7:0] o_tx_data,
   output wire       o_master_clear
);
`include "lpd_consts.vh"
   // Two-stage synchronisers for the reset, strobe, chip select, spare flag and strap pins
   reg  [1:0] s_rst_n;
   reg  [1:0] s_cs_n;
   reg  [1:0] s_rd_n;
   reg  [1:0] s_wr_n;
   reg  [1:0] s_aux_a;
   reg  [1:0] s_aux_b;
   reg  [1:0] s_system_controller_strap_n;
   reg        wr_n_d;
   reg  [7:0] status;
   reg  [7:0] frame_ctl;
   reg  [7:0] frame_data;
   reg  [7:0] poll_response_config;
   reg  [7:0] loop_address_config;
   reg  [7:0] scratch_a;
   reg  [7:0] scratch_b;
   reg        src_valid;
   reg  [2:0] src_ctl;
   reg  [7:0] src_data;
   reg  [7:0] next_rdata;
   reg  [2:0] rs_meta;
   reg  [2:0] rs_sync;
   reg  [7:0] bus_meta;
   reg  [7:0] bus_sync;
   wire       tx_in_valid;
   wire [2:0] tx_in_ctl;
   wire [7:0] tx_in_data;
   wire       mclr;
   wire       sel_rd;
   wire       wr_pulse;
   wire       send_srq;

   always @(posedge i_clk) begin
      if (i_rst) begin
         s_rst_n  <= `LPD_RST_SYNC;
         s_cs_n   <= `LPD_RST_SYNC;
         s_rd_n   <= `LPD_RST_SYNC;
         s_wr_n   <= `LPD_RST_SYNC;
         s_aux_a  <= `LPD_RST_SYNC;
         s_aux_b  <= `LPD_RST_SYNC;
         s_system_controller_strap_n <= `LPD_RST_SYNC;
         wr_n_d   <= 1'b1;
      end else begin
         s_rst_n  <= {s_rst_n[0], i_reset_n};
         s_cs_n   <= {s_cs_n[0], i_cs_n};
         s_rd_n   <= {s_rd_n[0], i_rd_n};
         s_wr_n   <= {s_wr_n[0], i_wr_n};
         s_aux_a  <= {s_aux_a[0], i_spare_flag_input_a};
         s_aux_b  <= {s_aux_b[0], i_spare_flag_input_b};
         s_system_controller_strap_n <= {s_system_controller_strap_n[0], i_system_controller_strap_n};
         wr_n_d   <= s_wr_n[1];
      end
   end

   // Register select and write data pass two stages as well; the host holds
   // them through the strobe, so the extra latency only delays read data
   always @(posedge i_clk) begin
      if (i_rst) begin
         rs_meta  <= `LPD_RST_CTL;
         rs_sync  <= `LPD_RST_CTL;
         bus_meta <= `LPD_RST_BYTE;
         bus_sync <= `LPD_RST_BYTE;
      end else begin
         rs_meta  <= i_register_select_lines;
         rs_sync  <= rs_meta;
         bus_meta <= i_bus;
         bus_sync <= bus_meta;
      end
   end

   // Active-low strobes decoded after synchronising
   assign sel_rd   = ~s_cs_n[1] & ~s_rd_n[1];
   assign wr_pulse = ~s_cs_n[1] & s_wr_n[1] & ~wr_n_d;  // Commit on rising WR edge
   assign mclr     = status[`LPD_ST_MASTER_CLR];
   assign send_srq = status[`LPD_ST_SEND_SRQ];
   assign o_master_clear = mclr;

   // Master clear blocks frames and the interrupt and clears frame control and data unless reset pin is low or a write lands; host clears it by writing the bit low
   always @(posedge i_clk) begin
      if (i_rst) begin
         status               <= `LPD_RST_STATUS;
         frame_ctl            <= `LPD_RST_BYTE;
         frame_data           <= `LPD_RST_BYTE;
         poll_response_config <= `LPD_RST_BYTE;
         loop_address_config  <= `LPD_RST_BYTE;
         scratch_a            <= `LPD_RST_BYTE;
         scratch_b            <= `LPD_RST_BYTE;
         src_valid            <= 1'b0;
         src_ctl              <= `LPD_RST_CTL;
         src_data             <= `LPD_RST_BYTE;
      end else begin
         src_valid <= 1'b0;
         // Reset pin wins over a write landing in the same cycle
         if (!s_rst_n[1]) begin
            status[`LPD_ST_MASTER_CLR] <= 1'b1;
            status[`LPD_ST_SYS_CTL]    <= ~s_system_controller_strap_n[1];
         end else if (wr_pulse) begin
            case (rs_sync)
               `LPD_REG_STATUS: begin
                  status <= bus_sync;
                  status[`LPD_ST_SYS_CTL] <= status[`LPD_ST_SYS_CTL];
               end
               `LPD_REG_FRAME_CTL:  frame_ctl <= bus_sync;
               `LPD_REG_FRAME_DATA: begin
                  // Every data write outside master clear sources a frame using the held control bits
                  frame_data <= bus_sync;
                  src_valid  <= ~mclr;
                  src_ctl    <= frame_ctl[2:0];
                  src_data   <= bus_sync;
               end
               `LPD_REG_POLL_CFG:   poll_response_config <= bus_sync;
               `LPD_REG_LOOP_ADDR:  loop_address_config  <= bus_sync;
               `LPD_REG_SCRATCH_A:  scratch_a <= bus_sync;
               `LPD_REG_SCRATCH_B:  scratch_b <= bus_sync;
               `LPD_REG_AUX_IN:     ;  // Read only
               default: ;
            endcase
         end
         if (mclr && s_rst_n[1] == 1'b1 && !wr_pulse) begin
            frame_ctl  <= `LPD_RST_BYTE;
            frame_data <= `LPD_RST_BYTE;
         end
      end
   end

   // Spare flags appear in the auxiliary register
   // Read data follows the synchronised select, so it lags the pins
   always @* begin
      case (rs_sync)
         `LPD_REG_STATUS:     next_rdata = status;
         `LPD_REG_FRAME_CTL:  next_rdata = frame_ctl;
         `LPD_REG_FRAME_DATA: next_rdata = frame_data;
         `LPD_REG_POLL_CFG:   next_rdata = poll_response_config;
         `LPD_REG_LOOP_ADDR:  next_rdata = loop_address_config;
         `LPD_REG_SCRATCH_A:  next_rdata = scratch_a;
         `LPD_REG_SCRATCH_B:  next_rdata = scratch_b;
         default:             next_rdata = {s_aux_b[1], s_aux_a[1], 6'h00};
      endcase
   end

   always @(posedge i_clk) begin
      if (i_rst)
         o_bus <= `LPD_RST_BYTE;
      else
         o_bus <= next_rdata;
   end
   assign o_bus_oe = sel_rd;

   // Open drain: only ever pulls low, enable high while driving
   assign o_irq_n_o  = 1'b0;
   assign o_irq_n_oe = i_irq_req & ~mclr;

   // Host-sourced frames take priority; retransmitted frames fill idle cycles.
   // A loop frame landing in the same cycle as a host frame is lost, so the
   // host must not source while retransmission traffic is expected
   assign tx_in_valid = src_valid | (i_rx_valid & ~mclr);
   assign tx_in_ctl   = src_valid ? src_ctl : i_rx_ctl;
   assign tx_in_data  = src_valid ? src_data : i_rx_data;

   lpd_srq_insert u_srq (
      .i_clk         (i_clk),
      .i_rst         (i_rst),
      .i_send_srq    (send_srq),
      .i_frame_valid (tx_in_valid),
      .i_frame_ctl   (tx_in_ctl),
      .i_frame_data  (tx_in_data),
      .o_frame_valid (o_tx_valid),
      .o_frame_ctl   (o_tx_ctl),
      .o_frame_data  (o_tx_data)
   );
endmodule

// >>> lpd_loop.sv
// Loop side frame source feeding the retransmit path
`timescale 1ns/1ps
module lpd_loop (
   input  wire logic        i_clk,
   input  wire logic        i_go,
   input  wire logic [10:0] i_frm,
   output logic             o_valid,
   output logic      [10:0] o_frm
);
   initial o_valid = 1'b0;
   initial o_frm = 11'h0;
   // Outside a frame the lines invert every cycle, so a stale frame never sits steady
   always @(posedge i_clk) begin
      o_valid <= i_go;
      o_frm <= i_go ? i_frm : ~o_frm;
   end
endmodule

// >>> lpd_srq_insert.v
// Service-request insertion on outgoing loop frames
`timescale 1ns/1ps
module lpd_srq_insert (
   input  wire       i_clk,
   input  wire       i_rst,
   input  wire       i_send_srq,
   input  wire       i_frame_valid,
   input  wire [2:0] i_frame_ctl,
   input  wire [7:0] i_frame_data,
   output reg        o_frame_valid,
   output reg  [2:0] o_frame_ctl,
   output reg  [7:0] o_frame_data
);
`include "lpd_consts.vh"
   wire is_doe;
   wire is_idy;
   reg  [2:0] next_ctl;

   assign is_doe = (i_frame_ctl[2] == `LPD_FC_DOE_MSB);
   assign is_idy = (i_frame_ctl[2:1] == `LPD_FC_IDY);

   always @* begin
      next_ctl = i_frame_ctl;
      if (i_send_srq && (is_doe || is_idy))
         next_ctl[`LPD_FC_SRQ] = 1'b1;
      // With the control bit clear the frame passes untouched
   end

   always @(posedge i_clk) begin
      if (i_rst) begin
         o_frame_valid <= 1'b0;
         o_frame_ctl   <= `LPD_RST_CTL;
         o_frame_data  <= `LPD_RST_BYTE;
      end else begin
         o_frame_valid <= i_frame_valid;
         o_frame_ctl   <= next_ctl;
         o_frame_data  <= i_frame_data;
      end
   end
endmodule
